// file: pfs_defines.vh
// Purpose: constants for the shared pin function select block
// Assumes: 10 MHz machine clock, plain register port, 8-bit registers
// Notes: register indices are word addresses on the register port
//
// How it works
// - port 0 is GPIO or low address/data
// - port 1 is GPIO or high address/data
// - port 2 low is GPIO unless address selected
// - upper address out when bus on and selected
// - latch enable strobe in bus mode, else GPIO
// - read strobe in bus mode, else GPIO
// - low write strobe when enabled in bus mode
// - high write strobe only 16-bit bus, enabled
// - timer output pins carry output when enabled
// - eight low-level wake-up inputs in single-chip
// - mode pins sampled to choose operating mode
// - low reset request starts a reset sequence
// - low standby input holds hardware standby
`ifndef PFS_DEFINES_VH
`define PFS_DEFINES_VH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define PFS_IDX_P0_DATA 4'h0
`define PFS_IDX_P0_DIR 4'h1
`define PFS_IDX_P1_DATA 4'h2
`define PFS_IDX_P1_DIR 4'h3
`define PFS_IDX_P2_DATA 4'h4
`define PFS_IDX_P2_DIR 4'h5
`define PFS_IDX_P3_CTRL 4'h6
`define PFS_IDX_FUNC_CTRL 4'h7
`define PFS_IDX_STATUS 4'h8
`define PFS_IDX_P0_PINS 4'h9
`define PFS_IDX_P1_PINS 4'ha
`define PFS_IDX_P2_PINS 4'hb
`define PFS_IDX_P3_PINS 4'hc

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PFS_FC_UPADDR_LSB 0
`define PFS_FC_WRL_EN 4
`define PFS_FC_WRH_EN 5
`define PFS_FC_TOUT0_EN 6
`define PFS_FC_TOUT1_EN 7
`define PFS_P3_DIR_LSB 4
`define PFS_ST_MODE_LSB 0
`define PFS_ST_EXT_BUS 3
`define PFS_ST_BUS16 4
`define PFS_ST_STANDBY 5
`define PFS_ST_RST_SEQ 6

// ----------------------------------------------------------------------
// reset values and mode codes
// ----------------------------------------------------------------------
`define PFS_REG_RESET 8'h00
`define PFS_MODE_SINGLE 3'h3
`define PFS_MODE_EXT16 3'h1
`define PFS_MODE_EXT8 3'h0
`define PFS_RST_SEQ_CYCLES 3'h4

`endif

// file: pfs_regfile.v
// Purpose: small register memory with registered read data
// Assumes: indices 0..7 writable, 8..15 read live status words
// Notes: read data stand for one cycle only, zero otherwise
`timescale 1ns/100ps
`include "pfs_defines.vh"

module pfs_regfile (
  input wire clk_i,
  input wire reset_n_i,
  input wire clear_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [63:0] status_i,
  output reg [7:0] rdata_o,
  output wire [63:0] regs_o
);

  reg [7:0] mem_reg [0:7];
  wire [7:0] rd_word;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_word
      always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          mem_reg[g] <= `PFS_REG_RESET;
        end else if (clear_i) begin
          mem_reg[g] <= `PFS_REG_RESET;
        end else if (wr_i && addr_i == g) begin
          mem_reg[g] <= wdata_i;
        end
      end
      assign regs_o[g*8 +: 8] = mem_reg[g];
    end
  endgenerate

  // upper half of the map is read-only status
  assign rd_word = addr_i[3] ? status_i[addr_i[2:0]*8 +: 8]
                             : mem_reg[addr_i[2:0]];

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rd_word;
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // pfs_regfile

// file: pfs_pin_select.v
// Purpose: chooses port or peripheral function for each shared pin
// Assumes: pin inputs synchronous to clk_i; oe_n low drives a pin
// Notes: mode pins are strapped, so they are caught on the first edge after reset and on every cycle of a reset sequence
`timescale 1ns/100ps
`include "pfs_defines.vh"

module pfs_pin_select (
  input wire clk_i,
  input wire reset_n_i,
  // register port
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  // straps and system pins
  input wire [2:0] mode_select_pins_i,
  input wire ext_reset_req_n_i,
  input wire hw_standby_n_i,
  // core-side bus and peripheral signals
  input wire [15:0] bus_ad_out_i,
  input wire bus_ad_oe_i,
  input wire [3:0] upper_addr_lines_i,
  input wire bus_ale_i,
  input wire bus_rd_n_i,
  input wire bus_wr_low_n_i,
  input wire bus_wr_high_n_i,
  input wire [1:0] reload_timer_out_i,
  output reg [15:0] bus_ad_in_o,
  output reg [1:0] reload_timer_event_in_o,
  output reg [7:0] wakeup_irq_in_o,
  output reg [2:0] mode_o,
  output reg ext_bus_o,
  output reg bus16_o,
  output reg reset_seq_o,
  output reg standby_o,
  // port 0 pins
  input wire [7:0] port0_pins_i,
  output reg [7:0] port0_pins_o,
  output reg [7:0] port0_pins_oe_n_o,
  // port 1 pins
  input wire [7:0] port1_pins_i,
  output reg [7:0] port1_pins_o,
  output reg [7:0] port1_pins_oe_n_o,
  // port 2 pins, low four carry upper address
  input wire [7:0] port2_pins_i,
  output reg [7:0] port2_pins_o,
  output reg [7:0] port2_pins_oe_n_o,
  // port 3 low pins, bus strobes
  input wire [3:0] port3_pins_i,
  output reg [3:0] port3_pins_o,
  output reg [3:0] port3_pins_oe_n_o
);

  // --------------------------------------------------------------------
  // reset request sequence and mode capture
  // --------------------------------------------------------------------
  reg [2:0] rst_cnt_reg;
  reg [2:0] rst_cnt_next;
  reg rst_seq_reg;
  reg mode_take_reg;
  reg [2:0] mode_reg;
  wire rst_seq_next;

  // request held low keeps the sequence reloaded
  always @* begin
    if (!ext_reset_req_n_i) begin
      rst_cnt_next = `PFS_RST_SEQ_CYCLES;
    end else if (rst_cnt_reg != 3'h0) begin
      rst_cnt_next = rst_cnt_reg - 3'h1;
    end else begin
      rst_cnt_next = 3'h0;
    end
  end
  assign rst_seq_next = (rst_cnt_next != 3'h0);

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_cnt_reg <= 3'h0;
      rst_seq_reg <= 1'b0;
      mode_take_reg <= 1'b1;
      mode_reg <= `PFS_MODE_SINGLE;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
      rst_seq_reg <= rst_seq_next;
      // strap caught by a clocked edge, never by the async reset
      mode_take_reg <= rst_seq_next;
      if (mode_take_reg) begin
        mode_reg <= mode_select_pins_i;
      end
    end
  end

  wire single_chip = (mode_reg == `PFS_MODE_SINGLE);
  wire ext_bus = ~single_chip;
  wire bus16 = ext_bus && (mode_reg == `PFS_MODE_EXT16);
  // pins float during a reset sequence as well as in standby
  wire standby = ~hw_standby_n_i;
  wire float_all = standby | rst_seq_reg;

  // --------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------
  wire [63:0] regs;
  wire [63:0] status_words;
  wire [7:0] p0_data = regs[8*`PFS_IDX_P0_DATA +: 8];
  wire [7:0] p0_dir = regs[8*`PFS_IDX_P0_DIR +: 8];
  wire [7:0] p1_data = regs[8*`PFS_IDX_P1_DATA +: 8];
  wire [7:0] p1_dir = regs[8*`PFS_IDX_P1_DIR +: 8];
  wire [7:0] p2_data = regs[8*`PFS_IDX_P2_DATA +: 8];
  wire [7:0] p2_dir = regs[8*`PFS_IDX_P2_DIR +: 8];
  wire [7:0] p3_ctrl = regs[8*`PFS_IDX_P3_CTRL +: 8];
  wire [7:0] func_ctrl = regs[8*`PFS_IDX_FUNC_CTRL +: 8];
  wire [3:0] p3_data = p3_ctrl[3:0];
  wire [3:0] p3_dir = p3_ctrl[`PFS_P3_DIR_LSB +: 4];
  wire [3:0] upaddr_sel = func_ctrl[`PFS_FC_UPADDR_LSB +: 4];
  wire [7:0] status_byte;

  assign status_byte = {1'b0, rst_seq_reg, standby, bus16, ext_bus,
                        mode_reg};
  // read-only words 8..15 in order: status, pin levels, zero
  assign status_words = {24'h000000, 4'h0, port3_pins_i, port2_pins_i,
                         port1_pins_i, port0_pins_i, status_byte};

  pfs_regfile u_regfile (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(rst_seq_reg),
    .addr_i(reg_addr_i),
    .wdata_i(reg_wdata_i),
    .wr_i(reg_wr_i),
    .rd_i(reg_rd_i),
    .status_i(status_words),
    .rdata_o(reg_rdata_o),
    .regs_o(regs)
  );

  // --------------------------------------------------------------------
  // port 0 and port 1: address/data bus or port
  // --------------------------------------------------------------------
  reg [7:0] p0_out_next;
  reg [7:0] p0_oe_n_next;
  reg [7:0] p1_out_next;
  reg [7:0] p1_oe_n_next;

  always @* begin
    if (ext_bus) begin
      p0_out_next = bus_ad_out_i[7:0];
      p0_oe_n_next = {8{~bus_ad_oe_i}};
      p1_out_next = bus_ad_out_i[15:8];
      p1_oe_n_next = {8{~bus_ad_oe_i}};
    end else begin
      p0_out_next = p0_data;
      p0_oe_n_next = ~p0_dir;
      p1_out_next = p1_data;
      p1_oe_n_next = ~p1_dir;
    end
    if (float_all) begin
      p0_oe_n_next = 8'hff;
      p1_oe_n_next = 8'hff;
    end
  end

  // --------------------------------------------------------------------
  // port 2: upper address, timer event inputs, timer outputs
  // --------------------------------------------------------------------
  wire [7:0] p2_out_next;
  wire [7:0] p2_oe_n_next;
  wire [7:0] p2_func;
  wire [7:0] p2_func_val;

  // port use in single-chip or when port is selected
  assign p2_func[3:0] = {4{ext_bus}} & upaddr_sel;
  assign p2_func_val[3:0] = upper_addr_lines_i;
  // bits 4 and 5 stay port pins; the far side drives them as
  // timer event inputs only with their direction left as input
  assign p2_func[5:4] = 2'h0;
  assign p2_func_val[5:4] = 2'h0;
  assign p2_func[6] = func_ctrl[`PFS_FC_TOUT0_EN];
  assign p2_func[7] = func_ctrl[`PFS_FC_TOUT1_EN];
  assign p2_func_val[7:6] = reload_timer_out_i;

  genvar gp;
  generate
    for (gp = 0; gp < 8; gp = gp + 1) begin : g_p2_pin
      assign p2_out_next[gp] = p2_func[gp] ? p2_func_val[gp]
                                           : p2_data[gp];
      // float wins over any selected function
      assign p2_oe_n_next[gp] = float_all |
                                (~p2_func[gp] & ~p2_dir[gp]);
    end
  endgenerate

  // --------------------------------------------------------------------
  // port 3 low: bus strobes
  // --------------------------------------------------------------------
  wire [3:0] p3_out_next;
  wire [3:0] p3_oe_n_next;
  wire [3:0] p3_func;
  wire [3:0] p3_func_val;

  assign p3_func[0] = ext_bus;
  assign p3_func[1] = ext_bus;
  assign p3_func[2] = ext_bus & func_ctrl[`PFS_FC_WRL_EN];
  assign p3_func[3] = bus16 & func_ctrl[`PFS_FC_WRH_EN];
  assign p3_func_val[0] = bus_ale_i;
  assign p3_func_val[1] = bus_rd_n_i;
  // one strobe serves both the low byte and an 8-bit bus
  assign p3_func_val[2] = bus_wr_low_n_i;
  assign p3_func_val[3] = bus_wr_high_n_i;

  genvar gs;
  generate
    for (gs = 0; gs < 4; gs = gs + 1) begin : g_p3_pin
      assign p3_out_next[gs] = p3_func[gs] ? p3_func_val[gs]
                                           : p3_data[gs];
      assign p3_oe_n_next[gs] = float_all |
                                (~p3_func[gs] & ~p3_dir[gs]);
    end
  endgenerate

  // --------------------------------------------------------------------
  // output flops
  // --------------------------------------------------------------------
  // one cycle of pin latency is traded for glitch-free pin outputs
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port0_pins_o <= 8'h00;
      port0_pins_oe_n_o <= 8'hff;
      port1_pins_o <= 8'h00;
      port1_pins_oe_n_o <= 8'hff;
      port2_pins_o <= 8'h00;
      port2_pins_oe_n_o <= 8'hff;
      port3_pins_o <= 4'h0;
      port3_pins_oe_n_o <= 4'hf;
      bus_ad_in_o <= 16'h0000;
      reload_timer_event_in_o <= 2'h0;
      wakeup_irq_in_o <= 8'h00;
      mode_o <= `PFS_MODE_SINGLE;
      ext_bus_o <= 1'b0;
      bus16_o <= 1'b0;
      reset_seq_o <= 1'b0;
      standby_o <= 1'b0;
    end else begin
      port0_pins_o <= p0_out_next;
      port0_pins_oe_n_o <= p0_oe_n_next;
      port1_pins_o <= p1_out_next;
      port1_pins_oe_n_o <= p1_oe_n_next;
      port2_pins_o <= p2_out_next;
      port2_pins_oe_n_o <= p2_oe_n_next;
      port3_pins_o <= p3_out_next;
      port3_pins_oe_n_o <= p3_oe_n_next;
      bus_ad_in_o <= {port1_pins_i, port0_pins_i};
      reload_timer_event_in_o <= port2_pins_i[5:4];
      // low level requests, masked outside single-chip mode
      wakeup_irq_in_o <= ~port1_pins_i & {8{single_chip}};
      mode_o <= mode_reg;
      ext_bus_o <= ext_bus;
      bus16_o <= bus16;
      reset_seq_o <= rst_seq_reg;
      standby_o <= standby;
    end
  end

endmodule // pfs_pin_select

// file: pfs_pin_select_assertions.sv
// Purpose: port checks for the shared pin function select
// Assumes: one clock, straps steady between resets
// Notes: func ctrl is shadowed from the register port
`timescale 1ns/100ps
module pfs_pin_select_assertions (
  input wire logic clk_i, reset_n_i, reg_wr_i, ext_reset_req_n_i,
  input wire logic hw_standby_n_i, bus_ad_oe_i, bus_ale_i, bus_rd_n_i,
  input wire logic bus_wr_low_n_i, bus_wr_high_n_i, ext_bus_o, bus16_o,
  input wire logic reset_seq_o, standby_o,
  input wire logic [3:0] reg_addr_i, upper_addr_lines_i,
  input wire logic [3:0] port3_pins_o, port3_pins_oe_n_o,
  input wire logic [2:0] mode_select_pins_i, mode_o,
  input wire logic [1:0] reload_timer_out_i,
  input wire logic [15:0] bus_ad_out_i,
  input wire logic [7:0] reg_wdata_i, port1_pins_i, wakeup_irq_in_o,
  input wire logic [7:0] port0_pins_o, port0_pins_oe_n_o, port1_pins_o,
  input wire logic [7:0] port1_pins_oe_n_o, port2_pins_o, port2_pins_oe_n_o
);
  logic [7:0] fc_q;
  logic ok;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // writes inside a reset sequence are lost, so clear there too
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      fc_q <= 8'h00;
    else if (reset_seq_o)
      fc_q <= 8'h00;
    else if (reg_wr_i && reg_addr_i == 4'h7)
      fc_q <= reg_wdata_i;
  end
  assign ok = hw_standby_n_i && ext_reset_req_n_i && !reset_seq_o &&
    !standby_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // quiet cycles so registered mode and float have settled
  sequence s_run;
    ok [*4];
  endsequence
  sequence s_ext;
    (ok && ext_bus_o) [*4];
  endsequence
  a_ad_drive: assert property (s_ext |->
    {port1_pins_o, port0_pins_o} == $past(bus_ad_out_i) &&
    {port1_pins_oe_n_o, port0_pins_oe_n_o} == {16{!$past(bus_ad_oe_i)}})
    else $error("ad pins not following core");
  a_strobe_pass: assert property (s_ext |->
    port3_pins_o[1:0] == $past({bus_rd_n_i, bus_ale_i}) &&
    port3_pins_oe_n_o[1:0] == 2'h0) else $error("ale or read strobe lost");
  a_wr_low: assert property (s_ext ##0 $past(fc_q[4]) |->
    !port3_pins_oe_n_o[2] && port3_pins_o[2] == $past(bus_wr_low_n_i))
    else $error("low write strobe lost");
  a_wr_high: assert property (s_ext ##0 ($past(fc_q[5]) && bus16_o) |->
    !port3_pins_oe_n_o[3] && port3_pins_o[3] == $past(bus_wr_high_n_i))
    else $error("high write strobe lost");
  a_upper_addr: assert property (s_ext |->
    ((((port2_pins_o[3:0] ^ $past(upper_addr_lines_i)) |
    port2_pins_oe_n_o[3:0]) & $past(fc_q[3:0])) == 4'h0))
    else $error("upper address not driven");
  a_timer_out: assert property (s_run |->
    ((((port2_pins_o[7:6] ^ $past(reload_timer_out_i)) |
    port2_pins_oe_n_o[7:6]) & $past(fc_q[7:6])) == 2'h0))
    else $error("timer output not driven");
  a_wake_level: assert property (s_run |->
    wakeup_irq_in_o == (~$past(port1_pins_i) & {8{!$past(ext_bus_o)}}))
    else $error("wake-up input wrong");
  a_standby_float: assert property (!hw_standby_n_i [*2] |->
    &{port0_pins_oe_n_o, port1_pins_oe_n_o, port2_pins_oe_n_o,
    port3_pins_oe_n_o}) else $error("pin driven in standby");
  a_seq_start: assert property ($fell(ext_reset_req_n_i) |->
    ##[1:4] reset_seq_o) else $error("reset sequence not started");
  a_mode_take: assert property ($rose(reset_n_i) |->
    ##2 mode_o == $past(mode_select_pins_i, 2)) else $error("mode not taken");
endmodule // pfs_pin_select_assertions

bind pfs_pin_select pfs_pin_select_assertions chk_i (.*);

// file: pfs_ext_mem.sv
// Purpose: far-side memory on ports 0 and 1, wake sources on port 1
// Assumes: pull-ups on all lines, memory answers while read is low
// Notes: device and memory driving together shows as unknown
`timescale 1ns/100ps
module pfs_ext_mem (
  input wire logic [15:0] ad_o,
  input wire logic [15:0] ad_oe_n,
  input wire logic rd_n,
  input wire logic rd_oe_n,
  input wire logic [15:0] rd_data,
  input wire logic [7:0] wake_low,
  output logic [15:0] ad_pins
);
  logic mem_on;
  assign mem_on = !rd_oe_n && !rd_n;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!ad_oe_n[i])
        ad_pins[i] = mem_on ? 1'bx : ad_o[i];
      else if (mem_on)
        ad_pins[i] = rd_data[i];
      else
        ad_pins[i] = !(i > 7 && wake_low[i % 8]);
    end
  end
endmodule // pfs_ext_mem

// file: tb_top.sv
// Purpose: self-checking bench for the shared pin function select
// Assumes: 10 MHz clock, straps move only under reset
// Notes: ports 2 and 3 have pull-ups, bench drives timer events
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic ext_reset_req_n_i = 1'b1, hw_standby_n_i = 1'b1, bus_ad_oe_i = 1'b0;
  logic bus_ale_i = 1'b0, bus_rd_n_i = 1'b1, bus_wr_low_n_i = 1'b1;
  logic bus_wr_high_n_i = 1'b1, ext_bus_o, bus16_o, reset_seq_o, standby_o;
  logic [3:0] reg_addr_i = 4'h0, upper_addr_lines_i = 4'h0;
  logic [3:0] port3_pins_i, port3_pins_o, port3_pins_oe_n_o;
  logic [2:0] mode_select_pins_i = 3'h3, mode_o;
  logic [1:0] reload_timer_out_i = 2'h0, reload_timer_event_in_o, ev = 2'h0;
  logic [15:0] bus_ad_out_i = 16'h0, bus_ad_in_o, rd_data = 16'h0;
  logic [7:0] reg_wdata_i = 8'h0, reg_rdata_o, wakeup_irq_in_o;
  logic [7:0] wake_low = 8'h0, port0_pins_i, port0_pins_o, port0_pins_oe_n_o;
  logic [7:0] port1_pins_i, port1_pins_o, port1_pins_oe_n_o;
  logic [7:0] port2_pins_i, port2_pins_o, port2_pins_oe_n_o;
  int miscompares = 0, n_compared = 0;

  pfs_pin_select dut (.*);
  pfs_ext_mem far (.ad_o({port1_pins_o, port0_pins_o}),
    .ad_oe_n({port1_pins_oe_n_o, port0_pins_oe_n_o}),
    .rd_n(port3_pins_o[1]), .rd_oe_n(port3_pins_oe_n_o[1]),
    .rd_data(rd_data), .wake_low(wake_low),
    .ad_pins({port1_pins_i, port0_pins_i}));
  // released lines show pull-ups, events only on released bits 4 and 5
  assign port2_pins_i = port2_pins_o & ~port2_pins_oe_n_o |
    port2_pins_oe_n_o & {2'h3, ev, 4'hf};
  assign port3_pins_i = port3_pins_o | port3_pins_oe_n_o;
  always #50 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    chk("read data", reg_rdata_o, exp);
  endtask
  // pins follow one edge behind, inputs one more
  task automatic settle;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic boot(logic [2:0] m);
    @(posedge clk_i);
    mode_select_pins_i <= m;
    reset_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    for (int m = 0; m < 8; m++) begin
      boot(m[2:0]);
      rd(4'h8, {3'h0, m == 1, m != 3, m[2:0]});
    end
    wr(4'h7, 8'h30);
    settle;
    chk("strobes 8", port3_pins_oe_n_o, 4'h8);
    $display("test modes done");
    boot(3'h3);
    wr(4'h0, 8'ha5);
    wr(4'h1, 8'hff);
    wr(4'h4, 8'h80);
    wr(4'h5, 8'hc0);
    wr(4'h7, 8'hcf);
    @(posedge clk_i);
    bus_ad_out_i <= 16'h1234;
    bus_ad_oe_i <= 1'b1;
    bus_rd_n_i <= 1'b0;
    reload_timer_out_i <= 2'h1;
    ev <= 2'h2;
    wake_low <= 8'h5a;
    settle;
    chk("port0", {port0_pins_oe_n_o, port0_pins_o}, 16'h00a5);
    chk("port1 oe", port1_pins_oe_n_o, 8'hff);
    chk("wake", wakeup_irq_in_o, 8'h5a);
    chk("timer out", port2_pins_o[7:6], 2'h1);
    chk("port2 oe", port2_pins_oe_n_o, 8'h3f);
    chk("event in", reload_timer_event_in_o, 2'h2);
    chk("port3 oe", port3_pins_oe_n_o, 4'hf);
    wr(4'h7, 8'h00);
    settle;
    chk("port2", {port2_pins_oe_n_o, port2_pins_o[7:6]}, 10'h0fe);
    $display("test single chip done");
    boot(3'h1);
    wr(4'h7, 8'h35);
    @(posedge clk_i);
    wake_low <= 8'h00;
    bus_rd_n_i <= 1'b1;
    upper_addr_lines_i <= 4'h5;
    bus_ale_i <= 1'b1;
    bus_wr_high_n_i <= 1'b0;
    settle;
    chk("ad out", {port1_pins_o, port0_pins_o}, 16'h1234);
    chk("ad oe", {port1_pins_oe_n_o, port0_pins_oe_n_o}, 16'h0);
    chk("upper", {port2_pins_oe_n_o[3:0], port2_pins_o[2], port2_pins_o[0]}, 6'h2b);
    chk("strobes", {port3_pins_oe_n_o, port3_pins_o}, 8'h07);
    chk("wake", wakeup_irq_in_o, 8'h00);
    @(posedge clk_i);
    bus_ad_oe_i <= 1'b0;
    bus_rd_n_i <= 1'b0;
    rd_data <= 16'hbeef;
    settle;
    chk("ad in", bus_ad_in_o, 16'hbeef);
    @(posedge clk_i);
    bus_rd_n_i <= 1'b1;
    hw_standby_n_i <= 1'b0;
    settle;
    chk("float", {port3_pins_oe_n_o, port2_pins_oe_n_o}, 12'hfff);
    chk("flags", {standby_o, bus16_o, ext_bus_o, mode_o}, 6'h39);
    @(posedge clk_i);
    hw_standby_n_i <= 1'b1;
    ext_reset_req_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk("sequence", {reset_seq_o, port3_pins_oe_n_o}, 5'h1f);
    @(posedge clk_i);
    ext_reset_req_n_i <= 1'b1;
    for (int k = 0; k < 12 && reset_seq_o !== 1'b0; k++)
      @(posedge clk_i);
    chk("sequence end", reset_seq_o, 1'b0);
    rd(4'h7, 8'h00);
    $display("test external bus done");
    print_verdict;
  end
  // whole run needs well under two thousand cycles
  initial begin
    #500000;
    miscompares++;
    print_verdict;
  end
endmodule // tb_top
